// >>> common/acc_pkg.sv
// Package for the audio clock check and serial format block.
package acc_pkg;

    // Register offsets.
    localparam logic [7:0] ACC_STATUS_ADDR    = 8'h04;
    localparam logic [7:0] ACC_CLKDET_ADDR    = 8'h25;
    localparam logic [7:0] ACC_FORMAT_ADDR    = 8'h28;
    localparam logic [7:0] ACC_MISSPER_ADDR   = 8'h2C;

    // Reset values.
    localparam logic [7:0] ACC_CLKDET_RESET   = 8'h00;
    localparam logic [7:0] ACC_FORMAT_RESET   = 8'h02;
    localparam logic [7:0] ACC_MISSPER_RESET  = 8'h00;

    // Field positions.
    localparam int ACC_IGN_FS_BIT      = 6;
    localparam int ACC_IGN_SCLK_BIT    = 5;
    localparam int ACC_IGN_MCLK_BIT    = 4;
    localparam int ACC_IGN_HALT_BIT    = 3;
    localparam int ACC_IGN_MISS_BIT    = 2;
    localparam int ACC_AUTOSET_DIS_BIT = 1;
    localparam int ACC_IGN_PLL_BIT     = 0;
    localparam int ACC_PLL_LOCK_BIT    = 4;
    localparam int ACC_FMT_LSB         = 4;
    localparam int ACC_WLEN_LSB        = 0;

    // Timing: one second of missing clocks and the master clock halt limit.
    localparam int ACC_SYS_CLK_HZ      = 100_000_000;
    localparam int ACC_MISS_UNIT_S     = 1;
    localparam int ACC_SECOND_CYCLES   = ACC_SYS_CLK_HZ * ACC_MISS_UNIT_S;
    localparam int ACC_HALT_NS         = 1000;
    localparam int ACC_HALT_CYCLES     = ACC_HALT_NS / 10;

    typedef enum logic [1:0] {
        ACC_FMT_I2S             = 2'b00,
        ACC_FMT_TDM             = 2'b01,
        ACC_FMT_RIGHT_JUSTIFIED = 2'b10,
        ACC_FMT_LEFT_JUSTIFIED  = 2'b11
    } acc_fmt_t;

    typedef enum logic [1:0] {
        ACC_WLEN_16 = 2'b00,
        ACC_WLEN_20 = 2'b01,
        ACC_WLEN_24 = 2'b10,
        ACC_WLEN_32 = 2'b11
    } acc_wlen_t;

    typedef struct packed {
        logic reserved;
        logic ignFs;
        logic ignSclk;
        logic ignMcklRatio;
        logic ignHalt;
        logic ignMissing;
        logic autosetDisable;
        logic ignPll;
    } acc_clkdet_t;

    typedef struct packed {
        logic [1:0] reservedHi;
        acc_fmt_t   format;
        logic [1:0] reservedLo;
        acc_wlen_t  wordLen;
    } acc_format_t;

endpackage

// >>> logic/acc_clock_check.sv
// Audio clock supervision, serial format registers and sample FIFO.
// Overview of operation
// - Ratio ignore bit masks master clock ratio error
// - Halted master clock raises error unless ignored
// - Both clocks missing forces power-down unless ignored
// - Disable bit stops automatic clock divider setup
// - PLL ignore bit masks unlock clock error
// - Status lock flag always shows true lock
// - Format field bits 5:4 select interface
// - Word length field bits 1:0 sets width
// - Ignore bits reset to zero, autoset enabled
// - Missing declared after 1 to 8 seconds low
`timescale 1ns/10ps

module acc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign inReady  = (count_r != (AW+1)'(DEPTH)) && !flush;
    assign outValid = (count_r != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady && !flush;
    assign outData  = mem[rdPtr_r];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module acc_clock_check
    import acc_pkg::*;
#(
    parameter int SECOND_CYCLES = ACC_SECOND_CYCLES,
    parameter int HALT_CYCLES   = ACC_HALT_CYCLES,
    parameter int SAMPLE_WIDTH  = 32,
    parameter int FIFO_DEPTH    = 8
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    // Register port.
    input  wire logic [7:0]              regAddr,
    input  wire logic                    regWrite,
    input  wire logic [7:0]              regWdata,
    input  wire logic                    regRead,
    output logic      [7:0]              regRdata,
    // Audio clock pins.
    input  wire logic                    mclkPin,
    input  wire logic                    sclkPin,
    input  wire logic                    frameSyncPin,
    // Status from the PLL and the sample-rate checkers.
    input  wire logic                    pllLocked,
    input  wire logic                    fsError,
    input  wire logic                    sclkError,
    // Sample stream in and out.
    input  wire logic [SAMPLE_WIDTH-1:0] sampleIn,
    input  wire logic                    sampleInValid,
    output logic                         sampleInReady,
    output logic      [SAMPLE_WIDTH-1:0] sampleOut,
    output logic                         sampleOutValid,
    input  wire logic                    sampleOutReady,
    // Controls to the clocking and the converter.
    output logic                         clockError,
    output logic                         powerDown,
    output logic                         autosetEnable,
    output acc_fmt_t                     audioFormat,
    output acc_wlen_t                    wordLength,
    output logic      [5:0]              wordBits
);
    acc_clkdet_t clkDet_r;
    acc_format_t format_r;
    logic [2:0]  missPeriod_r;
    logic [2:0]  mclkSync_r;
    logic [2:0]  sclkSync_r;
    logic [2:0]  fsSync_r;
    logic [15:0] haltCnt_r;
    logic        halted_r;
    logic [11:0] ratioCnt_r;
    logic        ratioErr_r;
    logic [29:0] missCnt_r;
    logic        missing_r;
    logic        mclkRise;
    logic        fsRise;
    logic [29:0] missLimit;

    function automatic logic validRatio(input logic [11:0] n);
        case (n)
            12'h080, 12'h0C0, 12'h100, 12'h180, 12'h200,
            12'h300, 12'h400, 12'h600, 12'h800: validRatio = 1'b1;
            default: validRatio = 1'b0;
        endcase
    endfunction

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clkDet_r     <= ACC_CLKDET_RESET;
            format_r     <= ACC_FORMAT_RESET;
            missPeriod_r <= ACC_MISSPER_RESET[2:0];
        end else if (regWrite) begin
            if (regAddr == ACC_CLKDET_ADDR) begin
                clkDet_r <= {1'b0, regWdata[6:0]};
            end else if (regAddr == ACC_FORMAT_ADDR) begin
                format_r <= {2'b00, regWdata[5:4], 2'b00, regWdata[1:0]};
            end else if (regAddr == ACC_MISSPER_ADDR) begin
                missPeriod_r <= regWdata[2:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            if (regAddr == ACC_STATUS_ADDR) begin
                regRdata <= 8'(pllLocked) << ACC_PLL_LOCK_BIT;
            end else if (regAddr == ACC_CLKDET_ADDR) begin
                regRdata <= clkDet_r;
            end else if (regAddr == ACC_FORMAT_ADDR) begin
                regRdata <= format_r;
            end else if (regAddr == ACC_MISSPER_ADDR) begin
                regRdata <= {5'h00, missPeriod_r};
            end else begin
                regRdata <= 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mclkSync_r <= 3'h0;
            sclkSync_r <= 3'h0;
            fsSync_r   <= 3'h0;
        end else begin
            mclkSync_r <= {mclkSync_r[1:0], mclkPin};
            sclkSync_r <= {sclkSync_r[1:0], sclkPin};
            fsSync_r   <= {fsSync_r[1:0], frameSyncPin};
        end
    end

    assign mclkRise = mclkSync_r[1] && !mclkSync_r[2];
    assign fsRise   = fsSync_r[1] && !fsSync_r[2];

    // Halt: no master clock edge within the halt window.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || mclkRise) begin
            haltCnt_r <= 16'h0000;
            halted_r  <= 1'b0;
        end else if (haltCnt_r >= 16'(HALT_CYCLES - 1)) begin
            halted_r <= 1'b1;
        end else begin
            haltCnt_r <= haltCnt_r + 16'h0001;
        end
    end

    // Ratio: master clock edges counted over one frame must match a known ratio.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ratioCnt_r <= 12'h000;
            ratioErr_r <= 1'b0;
        end else if (fsRise) begin
            ratioErr_r <= !validRatio(ratioCnt_r + 12'(mclkRise));
            ratioCnt_r <= 12'h000;
        end else if (mclkRise && ratioCnt_r != 12'hFFF) begin
            ratioCnt_r <= ratioCnt_r + 12'h001;
        end
    end

    assign missLimit = 30'(SECOND_CYCLES) * (30'(missPeriod_r) + 30'h1);

    // Missing: bit clock and frame sync both held low for the chosen period.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || sclkSync_r[1] || fsSync_r[1]) begin
            missCnt_r <= 30'h0;
            missing_r <= 1'b0;
        end else if (missCnt_r >= missLimit - 30'h1) begin
            missing_r <= 1'b1;
        end else begin
            missCnt_r <= missCnt_r + 30'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clockError <= 1'b0;
            powerDown  <= 1'b0;
        end else begin
            clockError <= (ratioErr_r && !clkDet_r.ignMcklRatio)
                        || (halted_r && !clkDet_r.ignHalt)
                        || (!pllLocked && !clkDet_r.ignPll)
                        || (fsError && !clkDet_r.ignFs)
                        || (sclkError && !clkDet_r.ignSclk);
            powerDown  <= missing_r && !clkDet_r.ignMissing;
        end
    end

    // Autoset must be turned off by software for reference-voltage PLL clocking.
    assign autosetEnable = !clkDet_r.autosetDisable;
    assign audioFormat   = format_r.format;
    assign wordLength    = format_r.wordLen;

    always_comb begin
        case (format_r.wordLen)
            ACC_WLEN_16: wordBits = 6'h10;
            ACC_WLEN_20: wordBits = 6'h14;
            ACC_WLEN_24: wordBits = 6'h18;
            default:     wordBits = 6'h20;
        endcase
    end

    // Samples are dropped and input stalled while the converter is powered down.
    acc_fifo #(
        .WIDTH (SAMPLE_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) sampleFifo (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .flush    (powerDown),
        .inData   (sampleIn),
        .inValid  (sampleInValid),
        .inReady  (sampleInReady),
        .outData  (sampleOut),
        .outValid (sampleOutValid),
        .outReady (sampleOutReady)
    );
endmodule

// >>> tb/acc_audio_source.sv
// Behavioural serial audio source driving the master, bit and frame clocks.
`timescale 1ns/10ps
module acc_audio_source (
    input  wire logic       sys_clk,
    input  wire logic [1:0] mode,
    output logic            mclkPin,
    output logic            sclkPin,
    output logic            frameSyncPin
);
    logic [9:0] cnt_r = 10'h000;

    always @(posedge sys_clk) cnt_r <= cnt_r + 10'h001;

    // Mode 0 stops all clocks low, 1 runs at a 256 ratio, 2 halts mclk, 3 gives a bad ratio.
    always_comb begin
        mclkPin      = (mode == 2'h1 || mode == 2'h3) && cnt_r[1];
        sclkPin      = mode != 2'h0 && cnt_r[3];
        frameSyncPin = mode != 2'h0 && (mode == 2'h3 ? cnt_r[6] : cnt_r[9]);
    end
endmodule

// >>> tb/acc_clock_check_properties.sv
// Checker of the clock supervision and format outputs.
`timescale 1ns/10ps
module acc_clock_check_props
    import acc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic [7:0] regWdata,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       sclkPin,
    input wire logic       pllLocked,
    input wire logic       fsError,
    input wire logic       sclkError,
    input wire logic       sampleInReady,
    input wire logic       clockError,
    input wire logic       powerDown,
    input wire logic       autosetEnable,
    input wire acc_fmt_t   audioFormat,
    input wire acc_wlen_t  wordLength,
    input wire logic [5:0] wordBits
);
    logic [7:0] ctl_r;
    logic [7:0] fmt_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Shadow copies of the two control registers.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctl_r <= ACC_CLKDET_RESET;
            fmt_r <= ACC_FORMAT_RESET;
        end else if (regWrite) begin
            if (regAddr == ACC_CLKDET_ADDR) ctl_r <= regWdata & 8'h7F;
            if (regAddr == ACC_FORMAT_ADDR) fmt_r <= regWdata & 8'h33;
        end
    end

    property p_pll; !pllLocked && !ctl_r[0] |=> clockError; endproperty
    a_pll: assert property (p_pll) else $error("no clock error on unlock");
    property p_det; (fsError && !ctl_r[6]) || (sclkError && !ctl_r[5]) |=> clockError; endproperty
    a_det: assert property (p_det) else $error("no clock error on fault");
    property p_quiet; &{ctl_r[6:3], ctl_r[0]} |=> !clockError; endproperty
    a_quiet: assert property (p_quiet) else $error("clock error while ignored");
    property p_auto; autosetEnable == !ctl_r[1]; endproperty
    a_auto: assert property (p_auto) else $error("autoset enable wrong");
    property p_fmt; audioFormat == fmt_r[5:4]; endproperty
    a_fmt: assert property (p_fmt) else $error("format wrong");
    property p_wlen;
        wordLength == fmt_r[1:0] &&
        wordBits == (fmt_r[1:0] == 2'h3 ? 6'h20 : 6'h10 + {2'h0, fmt_r[1:0], 2'h0});
    endproperty
    a_wlen: assert property (p_wlen) else $error("word length wrong");
    property p_stat; regRead && regAddr == ACC_STATUS_ADDR |=> regRdata[4] == $past(pllLocked); endproperty
    a_stat: assert property (p_stat) else $error("lock flag wrong");
    property p_pdclr; sclkPin |-> ##[1:4] !powerDown; endproperty
    a_pdclr: assert property (p_pdclr) else $error("power-down kept with clock");
    property p_pdrdy; powerDown |-> !sampleInReady; endproperty
    a_pdrdy: assert property (p_pdrdy) else $error("ready during power-down");
    property p_pdign; powerDown |-> !$past(ctl_r[2]); endproperty
    a_pdign: assert property (p_pdign) else $error("power-down while ignored");
    c_err: cover property (clockError && pllLocked);
    c_pd: cover property (powerDown);
    c_pll: cover property (!pllLocked && !ctl_r[0]);
    c_stat: cover property (regRead && regAddr == ACC_STATUS_ADDR);
endmodule

bind acc_clock_check acc_clock_check_props u_props (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .regAddr       (regAddr),
    .regWrite      (regWrite),
    .regWdata      (regWdata),
    .regRead       (regRead),
    .regRdata      (regRdata),
    .sclkPin       (sclkPin),
    .pllLocked     (pllLocked),
    .fsError       (fsError),
    .sclkError     (sclkError),
    .sampleInReady (sampleInReady),
    .clockError    (clockError),
    .powerDown     (powerDown),
    .autosetEnable (autosetEnable),
    .audioFormat   (audioFormat),
    .wordLength    (wordLength),
    .wordBits      (wordBits)
);

// >>> tb/audio_clock_check_and_format_tb_top.sv
// Self-checking bench for the audio clock check and format block.
`timescale 1ns/10ps
module audio_clock_check_and_format_tb_top
    import acc_pkg::*;
;
    logic sys_clk, sys_rst, regWrite, regRead, pllLocked, fsError, sclkError, took;
    logic sampleInValid, sampleOutReady, sampleInReady, sampleOutValid;
    logic clockError, powerDown, autosetEnable, mclkPin, sclkPin, frameSyncPin;
    logic [7:0]  regAddr, regWdata, regRdata, rd;
    logic [31:0] sampleIn, sampleOut;
    logic [5:0]  wordBits;
    logic [1:0]  mode;
    acc_fmt_t    audioFormat;
    acc_wlen_t   wordLength;
    int          n_fail, compares, cyc, seed, i;
    int          bitTab[5] = '{0, 6, 5, 3, 4};
    logic [31:0] q[$];

    acc_clock_check #(.SECOND_CYCLES(20), .HALT_CYCLES(16)) dut (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .regAddr        (regAddr),
        .regWrite       (regWrite),
        .regWdata       (regWdata),
        .regRead        (regRead),
        .regRdata       (regRdata),
        .mclkPin        (mclkPin),
        .sclkPin        (sclkPin),
        .frameSyncPin   (frameSyncPin),
        .pllLocked      (pllLocked),
        .fsError        (fsError),
        .sclkError      (sclkError),
        .sampleIn       (sampleIn),
        .sampleInValid  (sampleInValid),
        .sampleInReady  (sampleInReady),
        .sampleOut      (sampleOut),
        .sampleOutValid (sampleOutValid),
        .sampleOutReady (sampleOutReady),
        .clockError     (clockError),
        .powerDown      (powerDown),
        .autosetEnable  (autosetEnable),
        .audioFormat    (audioFormat),
        .wordLength     (wordLength),
        .wordBits       (wordBits)
    );
    acc_audio_source src (
        .sys_clk      (sys_clk),
        .mode         (mode),
        .mclkPin      (mclkPin),
        .sclkPin      (sclkPin),
        .frameSyncPin (frameSyncPin)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [5:0] wbits(logic [1:0] w);
        return w == 2'h3 ? 6'h20 : 6'h10 + {2'h0, w, 2'h0};
    endfunction

    task automatic wrap_up;
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        tick(1);
        regWrite <= 1'b0;
        tick(1);
    endtask

    task automatic rdchk(string nm, logic [7:0] a, logic [7:0] m, logic [7:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        tick(1);
        regRead <= 1'b0;
        tick(1);
        chk(nm, e, regRdata & m);
    endtask

    task automatic fault(int k, logic on);
        case (k)
            0: pllLocked <= !on;
            1: fsError <= on;
            2: sclkError <= on;
            3: mode <= on ? 2'h2 : 2'h1;
            default: mode <= on ? 2'h3 : 2'h1;
        endcase
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up;
        end
    end

    initial begin
        seed = 32'h14e8;
        {n_fail, compares, cyc} = '0;
        {regWrite, regRead, fsError, sclkError, sampleInValid, sampleOutReady} = '0;
        {regAddr, regWdata, sampleIn} = '0;
        pllLocked = 1'b1;
        mode = 2'h1;
        sys_rst = 1'b1;
        tick(3);
        sys_rst <= 1'b0;
        tick(1);
        rdchk("clkdet", ACC_CLKDET_ADDR, 8'hFF, ACC_CLKDET_RESET);
        rdchk("format", ACC_FORMAT_ADDR, 8'hFF, 8'h02);
        rdchk("unmapped", 8'h33, 8'hFF, 8'h00);
        chk("autoset", 1, autosetEnable);
        for (i = 0; i < 16; i++) begin
            rd = 8'(($random(seed) & 8'hCC) | ((i & 12) << 2) | (i & 3));
            wr(ACC_FORMAT_ADDR, rd);
            chk("fmt", rd[5:4], audioFormat);
            chk("wlen", rd[1:0], wordLength);
            chk("bits", wbits(rd[1:0]), wordBits);
            rdchk("fmtrd", ACC_FORMAT_ADDR, 8'hFF, rd & 8'h33);
        end
        for (i = 0; i < 5; i++) begin
            // Odd passes also switch automatic divider setup off.
            wr(ACC_CLKDET_ADDR, 8'h7D & ~(8'h01 << bitTab[i]) | {6'h0, i[0], 1'b0});
            chk("autoset", !i[0], autosetEnable);
            fault(i, 1'b1);
            tick(400);
            chk("clkErr", 1, clockError);
            wr(ACC_CLKDET_ADDR, 8'h7D);
            tick(4);
            chk("masked", 0, clockError);
            rdchk("lock", ACC_STATUS_ADDR, 8'h10, {3'h0, pllLocked, 4'h0});
            fault(i, 1'b0);
        end
        wr(ACC_CLKDET_ADDR, 8'h04);
        tick(2500);
        chk("clean", 0, clockError);
        wr(ACC_CLKDET_ADDR, 8'h79);
        wr(ACC_MISSPER_ADDR, 8'h01);
        mode <= 2'h0;
        tick(30);
        chk("pdEarly", 0, powerDown);
        tick(20);
        chk("pd", 1, powerDown);
        chk("inRdy", 0, sampleInReady);
        mode <= 2'h1;
        tick(24);
        chk("pdClr", 0, powerDown);
        wr(ACC_CLKDET_ADDR, 8'h7D);
        mode <= 2'h0;
        tick(60);
        chk("pdIgn", 0, powerDown);
        mode <= 2'h1;
        rdchk("missper", ACC_MISSPER_ADDR, 8'hFF, 8'h01);
        // A reset in mid-run must bring every control back to its default.
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        chk("pdRst", 0, powerDown);
        chk("autoRst", 1, autosetEnable);
        rdchk("ctlRst", ACC_CLKDET_ADDR, 8'hFF, ACC_CLKDET_RESET);
        rdchk("perRst", ACC_MISSPER_ADDR, 8'hFF, ACC_MISSPER_RESET);
        rdchk("fmtRst", ACC_FORMAT_ADDR, 8'hFF, ACC_FORMAT_RESET);
        sampleInValid <= 1'b1;
        sampleIn <= 32'($random(seed));
        repeat (10) begin
            @(negedge sys_clk);
            took = sampleInReady === 1'b1;
            if (took) q.push_back(sampleIn);
            @(posedge sys_clk);
            if (took) sampleIn <= 32'($random(seed));
        end
        sampleInValid <= 1'b0;
        chk("fill", 8, q.size());
        while (q.size() > 0 && cyc < 19000) begin
            sampleOutReady <= 1'($random(seed));
            @(negedge sys_clk);
            if (sampleOutValid === 1'b1 && sampleOutReady) chk("data", q.pop_front(), sampleOut);
            @(posedge sys_clk);
        end
        sampleOutReady <= 1'b0;
        tick(2);
        chk("empty", 0, sampleOutValid);
        wrap_up;
    end
endmodule
